/* rtl/chgsup_pkg.sv */
// Package for the charge safety supervisor: constants, encodings and carriers
package chgsup_pkg;

   // Register byte addresses (byte address = index * 4)
   localparam logic [7:0] ADDR_CFG_THERM  = 8'h00;
   localparam logic [7:0] ADDR_CFG_TIMER  = 8'h04;
   localparam logic [7:0] ADDR_CFG_SYS    = 8'h08;
   localparam logic [7:0] ADDR_STATUS     = 8'h0C;
   localparam logic [7:0] ADDR_OUTPUTS    = 8'h10;

   // Thermal config field positions
   localparam int WARM_VSEL_BIT   = 0;
   localparam int WARM_ISEL_LSB   = 1;
   localparam int COOL_ISEL_BIT   = 3;
   localparam int COOL_ALLOW_BIT  = 4;
   localparam int COOL_VSEL_BIT   = 5;
   localparam int COOL_BND_LSB    = 6;
   localparam int WARM_BND_LSB    = 8;
   // Timer / control config field positions
   localparam int TMR_EN_BIT      = 0;
   localparam int LONG_SEL_BIT    = 1;
   localparam int SLOW_ALLOW_BIT  = 2;
   localparam int CHG_ALLOW_BIT   = 3;
   localparam int SW_OFF_BIT      = 4;
   localparam int SW_DLY_BIT      = 5;
   localparam int FLOOR_LSB       = 0;

   localparam logic [9:0]  THERM_RESET   = 10'h1C2;
   localparam logic [5:0]  TIMER_RESET   = 6'h0F;
   localparam logic [2:0]  FLOOR_RESET   = 3'h5;   // 3.5V code

   // Voltage scale: millivolts
   localparam logic [12:0] WARM_COOL_VMAX_MV = 13'd4100;

   // Current scale codes (percent)
   localparam logic [6:0]  PCT_FULL = 7'd100;
   localparam logic [6:0]  PCT_HALF = 7'd50;
   localparam logic [6:0]  PCT_FIFTH = 7'd20;
   localparam logic [6:0]  PCT_NONE = 7'd0;

   // Fault codes
   localparam logic [1:0]  CHG_FAULT_TIMER = 2'h3;
   localparam logic [1:0]  CHG_FAULT_NONE  = 2'h0;
   localparam logic [2:0]  NTC_NORMAL      = 3'h0;
   localparam logic [2:0]  NTC_BOOST_COLD  = 3'h5;
   localparam logic [2:0]  NTC_BOOST_HOT   = 3'h6;
   localparam logic [2:0]  SRC_NONE        = 3'h0;
   localparam logic [2:0]  SRC_BOOST       = 3'h7;

   // Timing
   localparam longint CLK_HZ          = 200_000_000;
   localparam longint SEC_SHORT_LIMIT = 2 * 3600;
   localparam longint SEC_LONG_LIMIT  = 16 * 3600;
   localparam longint SEC_MID_LIMIT   = 7 * 3600;
   localparam longint SHIP_DLY_SEC    = 12;
   localparam longint IRQ_PULSE_NS    = 256_000;
   localparam longint IRQ_PULSE_CYC   = (IRQ_PULSE_NS * CLK_HZ) / 1_000_000_000;

   typedef enum logic [2:0] {
      ZONE_COLD   = 3'b000,
      ZONE_COOL   = 3'b001,
      ZONE_NORMAL = 3'b010,
      ZONE_WARM   = 3'b011,
      ZONE_HOT    = 3'b100
   } chgsup_zone_t;

   // Thermistor comparator outputs (1 = sense voltage above that threshold)
   typedef struct packed {
      logic       aboveCold;      // Colder than T1
      logic [3:0] aboveCool;      // Per cool boundary option
      logic [3:0] aboveWarm;      // Per warm boundary option
      logic       aboveHot;       // Still cooler than T4
      logic       boostCold;
      logic       boostHot;
   } chgsup_therm_t;

   // Analog loop status inputs
   typedef struct packed {
      logic inCurLimit;
      logic inVoltLimit;
      logic thermalReg;
      logic floorReg;
      logic sysBelowBat45;
      logic batDepleted;
      logic batAboveLow;
      logic batBelowTarget;
      logic boostMode;
      logic restart;
   } chgsup_loop_t;

   // Charge control outputs
   typedef struct packed {
      logic        chargeOn;
      logic [12:0] voltTargetMv;
      logic [6:0]  currentPct;
      logic        inputLimitCut;
      logic        boostOn;
      logic        switchOn;
      logic        supplement;
   } chgsup_ctrl_t;

endpackage

/* rtl/chgsup_top.sv */
// Charge safety supervisor: thermal zones, safety timer, regulation flags, battery switch
//
// Overview of operation
// - Start a charge cycle only while the thermistor reading sits inside cold-hot window
// - Leaving the window during charge suspends with zero current until it returns
// - Warm zone voltage: lower of target and 4.1V if select 0, else target
// - Warm zone current scales to 0, 20, 50 or 100 percent by two-bit select
// - Cool zone current 50 or 20 percent when allowed, otherwise zero
// - Cool zone voltage: full target if select 0, else lower of target and 4.1V
// - Cool and warm boundaries are chosen by two separate two-bit fields
// - Boost out of window suspends boost, source status 000, fault code cold/hot
// - Timer expiry stops charging, sets charge fault 11 and pulses the interrupt
// - Limit 2h below low-battery, 16h above, 7h if long select cleared; enable
// - Timer runs half rate in input, cool or thermal regulation unless disallowed
// - Timer holds while a fault suspends charge and continues afterwards
// - Timer resets on restart or toggling of enable pin or allow bit
// - Three-bit system floor select, reset value means 3.5V
// - Floor regulation flag follows minimum system regulation
// - Input current and voltage limit flags follow their regulation loops
// - Either input limit reached cuts charge current
// - System 45mV below battery turns battery switch on, supplement mode
// - Battery below depletion turns switch off, leaving supplement mode
// - Switch off bit opens switch at once, or after 12 s with delay bit
// - Each interrupt is one active-low 256us pulse
`timescale 1ns/10ps
module chgsup_top
   import chgsup_pkg::*;
#(
   parameter longint TICK_CYCLES = CLK_HZ,   // Cycles per timer second
   parameter int     TMR_WIDTH   = 48
) (
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire logic [7:0]              regAddr,
   input  wire logic [15:0]             regWrData,
   input  wire logic                    regWrStb,
   input  wire logic                    regRdStb,
   output logic [15:0]                  regRdData,
   input  wire logic [12:0]             chargeVoltageTarget,
   input  wire logic                    chargeEnablePin_n,
   input  wire chgsup_pkg::chgsup_therm_t thermistorSense,
   input  wire chgsup_pkg::chgsup_loop_t  loopStatus,
   output chgsup_pkg::chgsup_ctrl_t     chargeCtrl,
   output logic                         hostIrqPulse_n
);
   import chgsup_pkg::*;

   localparam longint SHIP_DLY_CYC = SHIP_DLY_SEC * TICK_CYCLES;

   initial begin
      if (TICK_CYCLES < 2 || TMR_WIDTH < 20 || TMR_WIDTH > 62)
         $error("chgsup_top: unsupported parameter values");
   end

   // Configuration registers
   logic [9:0]   thermCfg_q;
   logic [5:0]   timerCfg_q;
   logic [2:0]   floorSel_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thermCfg_q <= THERM_RESET;
         timerCfg_q <= TIMER_RESET;
         floorSel_q <= FLOOR_RESET;
      end else if (regWrStb) begin
         case (regAddr)
            ADDR_CFG_THERM: thermCfg_q <= regWrData[9:0];
            ADDR_CFG_TIMER: timerCfg_q <= regWrData[5:0];
            ADDR_CFG_SYS:   floorSel_q <= regWrData[FLOOR_LSB +: 3];
            default: ;
         endcase
      end
   end

   chgsup_therm_t thermMeta_q;
   chgsup_therm_t thermSync_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thermMeta_q <= '0;
         thermSync_q <= '0;
      end else begin
         thermMeta_q <= thermistorSense;
         thermSync_q <= thermMeta_q;
      end
   end

   chgsup_zone_t zone_q;
   logic coolEdge;
   logic warmEdge;
   assign coolEdge = thermSync_q.aboveCool[thermCfg_q[COOL_BND_LSB +: 2]];
   assign warmEdge = thermSync_q.aboveWarm[thermCfg_q[WARM_BND_LSB +: 2]];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         zone_q <= ZONE_COLD;
      else if (thermSync_q.aboveCold)
         zone_q <= ZONE_COLD;
      else if (!thermSync_q.aboveHot)
         zone_q <= ZONE_HOT;
      else if (coolEdge)
         zone_q <= ZONE_COOL;
      else if (!warmEdge)
         zone_q <= ZONE_WARM;
      else
         zone_q <= ZONE_NORMAL;
   end

   logic inWindow;
   assign inWindow = (zone_q != ZONE_COLD) && (zone_q != ZONE_HOT);

   // Charge enable and toggle detection
   logic chgAllow;
   logic chgEnable;
   logic chgEnablePrev_q;
   logic swOffBit;
   assign chgAllow  = timerCfg_q[CHG_ALLOW_BIT];
   assign swOffBit  = timerCfg_q[SW_OFF_BIT];
   assign chgEnable = chgAllow && !chargeEnablePin_n;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         chgEnablePrev_q <= 1'b0;
      else
         chgEnablePrev_q <= chgEnable;
   end

   // Charge session state
   logic cycleActive_q;
   logic timerFault_q;
   logic restartCycle;
   assign restartCycle = loopStatus.restart || (chgEnable != chgEnablePrev_q);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         cycleActive_q <= 1'b0;
      else if (!chgEnable || restartCycle || timerFault_q || swOffBit)
         cycleActive_q <= 1'b0;
      else if (!cycleActive_q && inWindow && loopStatus.batBelowTarget && !loopStatus.boostMode)
         cycleActive_q <= 1'b1;
   end

   logic chargeRun;
   logic coolBlocked;
   assign coolBlocked = (zone_q == ZONE_COOL) && !thermCfg_q[COOL_ALLOW_BIT];
   assign chargeRun   = cycleActive_q && inWindow && !timerFault_q;

   // Safety timer
   logic [TMR_WIDTH-1:0] tickCnt_q;
   logic [TMR_WIDTH-1:0] elapsed_q;
   logic [TMR_WIDTH-1:0] limitSec;
   logic                 halfPhase_q;
   logic                 slowCount;
   logic                 timerRun;
   logic                 reachedLow_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         reachedLow_q <= 1'b0;
      else if (restartCycle)
         reachedLow_q <= 1'b0;
      else if (chargeRun && loopStatus.batAboveLow)
         reachedLow_q <= 1'b1;
   end

   always_comb begin
      if (!reachedLow_q)
         limitSec = TMR_WIDTH'(SEC_SHORT_LIMIT);
      else if (timerCfg_q[LONG_SEL_BIT])
         limitSec = TMR_WIDTH'(SEC_LONG_LIMIT);
      else
         limitSec = TMR_WIDTH'(SEC_MID_LIMIT);
   end

   assign slowCount = timerCfg_q[SLOW_ALLOW_BIT] && (loopStatus.inCurLimit || loopStatus.inVoltLimit
                      || loopStatus.thermalReg || zone_q == ZONE_COOL);
   // counting only while charging is not suspended
   assign timerRun = chargeRun && !coolBlocked && timerCfg_q[TMR_EN_BIT];

   logic timerExpire;
   assign timerExpire = timerRun && (elapsed_q >= limitSec);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt_q   <= '0;
         elapsed_q   <= '0;
         halfPhase_q <= 1'b0;
      end else if (restartCycle || !timerCfg_q[TMR_EN_BIT]) begin
         tickCnt_q   <= '0;
         elapsed_q   <= '0;
         halfPhase_q <= 1'b0;
      end else if (timerRun) begin
         if (tickCnt_q == TMR_WIDTH'(TICK_CYCLES - 1)) begin
            tickCnt_q <= '0;
            // count every second tick when slowed
            if (!slowCount || halfPhase_q)
               elapsed_q <= elapsed_q + 1'b1;
            halfPhase_q <= slowCount ? !halfPhase_q : 1'b0;
         end else begin
            tickCnt_q <= tickCnt_q + 1'b1;
         end
      end
   end

   logic [1:0] chgFault_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         timerFault_q <= 1'b0;
         chgFault_q   <= CHG_FAULT_NONE;
      end else if (timerExpire) begin
         timerFault_q <= 1'b1;
         chgFault_q   <= CHG_FAULT_TIMER;
      end else if (restartCycle) begin
         timerFault_q <= 1'b0;
         chgFault_q   <= CHG_FAULT_NONE;
      end
   end

   logic [2:0] ntcFault_q;
   logic [2:0] srcStatus_q;
   logic       boostOn_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ntcFault_q  <= NTC_NORMAL;
         srcStatus_q <= SRC_NONE;
         boostOn_q   <= 1'b0;
      end else if (!loopStatus.boostMode) begin
         ntcFault_q  <= NTC_NORMAL;
         srcStatus_q <= SRC_NONE;
         boostOn_q   <= 1'b0;
      end else if (thermSync_q.boostCold) begin
         ntcFault_q  <= NTC_BOOST_COLD;
         srcStatus_q <= SRC_NONE;
         boostOn_q   <= 1'b0;
      end else if (thermSync_q.boostHot) begin
         ntcFault_q  <= NTC_BOOST_HOT;
         srcStatus_q <= SRC_NONE;
         boostOn_q   <= 1'b0;
      end else begin
         ntcFault_q  <= NTC_NORMAL;
         srcStatus_q <= SRC_BOOST;
         boostOn_q   <= 1'b1;
      end
   end

   // Charge voltage and current targets
   logic [12:0] capVolt;
   assign capVolt = (chargeVoltageTarget < WARM_COOL_VMAX_MV) ? chargeVoltageTarget : WARM_COOL_VMAX_MV;

   chgsup_ctrl_t ctrl_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= '0;
      end else begin
         ctrl_q.chargeOn      <= chargeRun && !coolBlocked;
         ctrl_q.voltTargetMv  <= chargeVoltageTarget;
         ctrl_q.currentPct    <= chargeRun ? PCT_FULL : PCT_NONE;
         ctrl_q.inputLimitCut <= loopStatus.inCurLimit || loopStatus.inVoltLimit;
         ctrl_q.boostOn       <= boostOn_q;
         case (zone_q)
            ZONE_WARM: begin
               if (!thermCfg_q[WARM_VSEL_BIT])
                  ctrl_q.voltTargetMv <= capVolt;
               case (thermCfg_q[WARM_ISEL_LSB +: 2])
                  2'h0:    ctrl_q.currentPct <= PCT_NONE;
                  2'h1:    ctrl_q.currentPct <= chargeRun ? PCT_FIFTH : PCT_NONE;
                  2'h2:    ctrl_q.currentPct <= chargeRun ? PCT_HALF : PCT_NONE;
                  default: ctrl_q.currentPct <= chargeRun ? PCT_FULL : PCT_NONE;
               endcase
            end
            ZONE_COOL: begin
               if (thermCfg_q[COOL_VSEL_BIT])
                  ctrl_q.voltTargetMv <= capVolt;
               if (!thermCfg_q[COOL_ALLOW_BIT] || !chargeRun)
                  ctrl_q.currentPct <= PCT_NONE;
               else
                  ctrl_q.currentPct <= thermCfg_q[COOL_ISEL_BIT] ? PCT_FIFTH : PCT_HALF;
            end
            default: ;
         endcase
      end
   end

   // Battery switch and ship mode
   logic [TMR_WIDTH-1:0] shipCnt_q;
   logic                 shipOpen_q;
   logic                 switchOn_q;
   logic                 supplement_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shipCnt_q  <= '0;
         shipOpen_q <= 1'b0;
      end else if (!swOffBit) begin
         shipCnt_q  <= '0;
         shipOpen_q <= 1'b0;
      end else if (!timerCfg_q[SW_DLY_BIT] || shipCnt_q == TMR_WIDTH'(SHIP_DLY_CYC - 1)) begin
         shipOpen_q <= 1'b1;
      end else if (!shipOpen_q) begin
         shipCnt_q <= shipCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         switchOn_q   <= 1'b0;
         supplement_q <= 1'b0;
      end else if (shipOpen_q || loopStatus.batDepleted) begin
         switchOn_q   <= 1'b0;
         supplement_q <= 1'b0;
      end else if (loopStatus.sysBelowBat45) begin
         switchOn_q   <= 1'b1;
         supplement_q <= 1'b1;
      end else begin
         switchOn_q   <= chargeRun;
         supplement_q <= 1'b0;
      end
   end

   assign chargeCtrl = '{chargeOn: ctrl_q.chargeOn, voltTargetMv: ctrl_q.voltTargetMv,
                         currentPct: ctrl_q.currentPct, inputLimitCut: ctrl_q.inputLimitCut,
                         boostOn: ctrl_q.boostOn, switchOn: switchOn_q, supplement: supplement_q};

   localparam int IRQ_W = $clog2(IRQ_PULSE_CYC + 1);
   logic [IRQ_W-1:0] irqCnt_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irqCnt_q       <= '0;
         hostIrqPulse_n <= 1'b1;
      end else if (timerExpire && !timerFault_q) begin
         irqCnt_q       <= IRQ_W'(IRQ_PULSE_CYC - 1);
         hostIrqPulse_n <= 1'b0;
      end else if (irqCnt_q != '0) begin
         irqCnt_q <= irqCnt_q - 1'b1;
      end else begin
         hostIrqPulse_n <= 1'b1;
      end
   end

   // Status flags and readback
   logic [2:0] statusFlags_q;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         statusFlags_q <= '0;
      else
         statusFlags_q <= {loopStatus.floorReg, loopStatus.inCurLimit, loopStatus.inVoltLimit};
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= '0;
      end else if (regRdStb) begin
         case (regAddr)
            ADDR_CFG_THERM: regRdData <= {6'h00, thermCfg_q};
            ADDR_CFG_TIMER: regRdData <= {10'h000, timerCfg_q};
            ADDR_CFG_SYS:   regRdData <= {13'h0000, floorSel_q};
            ADDR_STATUS:    regRdData <= {zone_q, statusFlags_q, chgFault_q, ntcFault_q, srcStatus_q, cycleActive_q,
                                          1'b0};
            ADDR_OUTPUTS:   regRdData <= {switchOn_q, supplement_q, shipOpen_q, 13'h0000};
            default:        regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

endmodule

/* verification/chgsup_checker.sv */
// Port-level assertions for the charge safety supervisor
`timescale 1ns/10ps
module chgsup_checker
   import chgsup_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      sys_rst,
   input wire logic [7:0]                regAddr,
   input wire logic [15:0]               regWrData,
   input wire logic                      regWrStb,
   input wire logic                      regRdStb,
   input wire logic [15:0]               regRdData,
   input wire logic [12:0]               chargeVoltageTarget,
   input wire logic                      chargeEnablePin_n,
   input wire chgsup_pkg::chgsup_therm_t thermistorSense,
   input wire chgsup_pkg::chgsup_loop_t  loopStatus,
   input wire chgsup_pkg::chgsup_ctrl_t  chargeCtrl,
   input wire logic                      hostIrqPulse_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   int lowCnt_q;
   // Counts the current low stretch of the interrupt line
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         lowCnt_q <= 0;
      else if (!hostIrqPulse_n)
         lowCnt_q <= lowCnt_q + 1;
      else
         lowCnt_q <= 0;
   end
   property p_irqLen;
      $rose(hostIrqPulse_n) |-> lowCnt_q == IRQ_PULSE_CYC;
   endproperty
   a_irqLen: assert property (p_irqLen) else $error("interrupt pulse length wrong");
   property p_irqMax;
      lowCnt_q <= IRQ_PULSE_CYC;
   endproperty
   a_irqMax: assert property (p_irqMax) else $error("interrupt pulse too long");
   property p_rdIdle;
      !$past(regRdStb) |-> regRdData == 16'h0000;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");
   property p_hot;
      (!thermistorSense.aboveHot) [*5] |-> !chargeCtrl.chargeOn && chargeCtrl.currentPct == PCT_NONE;
   endproperty
   a_hot: assert property (p_hot) else $error("charging while hot");
   property p_cold;
      thermistorSense.aboveCold [*5] |-> !chargeCtrl.chargeOn && chargeCtrl.currentPct == PCT_NONE;
   endproperty
   a_cold: assert property (p_cold) else $error("charging while cold");
   property p_cut;
      (loopStatus.inCurLimit || loopStatus.inVoltLimit) [*5] ##0 chargeCtrl.chargeOn |-> chargeCtrl.inputLimitCut;
   endproperty
   a_cut: assert property (p_cut) else $error("input limit without current cut");
   property p_boost;
      (loopStatus.boostMode && (thermistorSense.boostCold || thermistorSense.boostHot)) [*5] |-> !chargeCtrl.boostOn;
   endproperty
   a_boost: assert property (p_boost) else $error("boost outside window");
   property p_supp;
      $rose(loopStatus.sysBelowBat45) && !loopStatus.batDepleted |-> ##[1:5] chargeCtrl.supplement;
   endproperty
   a_supp: assert property (p_supp) else $error("supplement not entered");
   property p_depl;
      loopStatus.batDepleted [*5] |-> !chargeCtrl.supplement;
   endproperty
   a_depl: assert property (p_depl) else $error("supplement on depleted battery");
   property p_volt;
      chargeCtrl.chargeOn && $stable(chargeVoltageTarget) |-> chargeCtrl.voltTargetMv <= chargeVoltageTarget;
   endproperty
   a_volt: assert property (p_volt) else $error("voltage above target");
   c_irq: cover property ($fell(hostIrqPulse_n));
   c_supp: cover property ($rose(chargeCtrl.supplement));
   c_boost: cover property ($fell(chargeCtrl.boostOn));
endmodule

/* verification/chgsup_far_model.sv */
// Far-side model: thermistor comparator bank
`timescale 1ns/10ps
module chgsup_far_model
   import chgsup_pkg::*;
(
   input  wire logic [2:0]           zone,
   input  wire logic [1:0]           boostWin,
   output chgsup_pkg::chgsup_therm_t sense
);
   // Sense voltage falls as heat rises, so every warmer comparator trips too
   // comparator levels
   always_comb begin
      sense.aboveCold = (zone == ZONE_COLD);
      sense.aboveCool = (zone <= ZONE_COOL) ? 4'hF : 4'h0;
      sense.aboveWarm = (zone <= ZONE_NORMAL) ? 4'hF : 4'h0;
      sense.aboveHot  = (zone != ZONE_HOT);
      sense.boostCold = boostWin[0];
      sense.boostHot  = boostWin[1];
   end
endmodule

/* verification/test_chgsup_top.sv */
// Self-checking bench for the charge safety supervisor
`timescale 1ns/10ps
module test_chgsup_top;
   import chgsup_pkg::*;
   logic          clk_sys = 1'b0;
   logic          sys_rst = 1'b1;
   logic [7:0]    regAddr = 8'h00;
   logic [15:0]   regWrData = 16'h0000;
   logic          regWrStb = 1'b0;
   logic          regRdStb = 1'b0;
   logic [15:0]   regRdData;
   logic [12:0]   vTgt = 13'h1070;
   logic          cePin_n = 1'b0;
   logic [2:0]    zone = ZONE_COLD;
   logic [1:0]    boostWin = 2'h0;
   chgsup_therm_t sense;
   chgsup_loop_t  loops;
   chgsup_ctrl_t  ctrl;
   logic          irq_n;
   logic [15:0]   rv;
   int            fails = 0;
   int            n_tests = 0;
   realtime       tF;
   always #2.5 clk_sys = ~clk_sys;
   chgsup_top #(.TICK_CYCLES(4)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .chargeVoltageTarget(vTgt), .chargeEnablePin_n(cePin_n), .thermistorSense(sense),
      .loopStatus(loops), .chargeCtrl(ctrl), .hostIrqPulse_n(irq_n));
   chgsup_far_model far (.zone(zone), .boostWin(boostWin), .sense(sense));
   task automatic end_sim;
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      #1 rv = regRdData;
   endtask
   task automatic setz(input logic [2:0] z);
      zone <= z;
      cyc(6);
   endtask
   task automatic t_reset;
      chk(16'(irq_n), 16'h0001);
      rd(ADDR_CFG_THERM);
      chk(rv, 16'h01C2);
      rd(ADDR_CFG_TIMER);
      chk(rv, 16'h000F);
      rd(ADDR_CFG_SYS);
      chk(rv, 16'h0005);
      rd(8'h14);
      chk(rv, 16'h0000);
   endtask
   task automatic t_zones;
      setz(ZONE_COLD);
      rd(ADDR_STATUS);
      chk(16'(rv[15:13]), 16'h0000);
      chk(16'(ctrl.chargeOn), 16'h0000);
      setz(ZONE_NORMAL);
      chk(16'(ctrl.chargeOn), 16'h0001);
      chk(16'(ctrl.currentPct), 16'h0064);
      setz(ZONE_WARM);
      rd(ADDR_STATUS);
      chk(16'(rv[15:13]), 16'h0003);
      chk(16'(ctrl.voltTargetMv), 16'h1004);
      chk(16'(ctrl.currentPct), 16'h0014);
      wr(ADDR_CFG_THERM, 16'h01C5);
      cyc(3);
      chk(16'(ctrl.voltTargetMv), 16'h1070);
      chk(16'(ctrl.currentPct), 16'h0032);
      wr(ADDR_CFG_THERM, 16'h01C1);
      cyc(3);
      chk(16'(ctrl.currentPct), 16'h0000);
      setz(ZONE_COOL);
      chk(16'(ctrl.currentPct), 16'h0000);
      wr(ADDR_CFG_THERM, 16'h01F8);
      cyc(3);
      chk(16'(ctrl.currentPct), 16'h0014);
      chk(16'(ctrl.voltTargetMv), 16'h1004);
      wr(ADDR_CFG_THERM, 16'h01D0);
      cyc(3);
      chk(16'(ctrl.currentPct), 16'h0032);
      chk(16'(ctrl.voltTargetMv), 16'h1070);
      setz(ZONE_HOT);
      chk(16'(ctrl.chargeOn), 16'h0000);
      chk(16'(ctrl.currentPct), 16'h0000);
      setz(ZONE_NORMAL);
      chk(16'(ctrl.chargeOn), 16'h0001);
      wr(ADDR_CFG_THERM, 16'h01C2);
   endtask
   task automatic t_flags;
      loops.inCurLimit <= 1'b1;
      cyc(4);
      rd(ADDR_STATUS);
      chk(16'(rv[12:10]), 16'h0002);
      chk(16'(ctrl.inputLimitCut), 16'h0001);
      loops.inCurLimit <= 1'b0;
      loops.inVoltLimit <= 1'b1;
      loops.floorReg <= 1'b1;
      cyc(4);
      rd(ADDR_STATUS);
      chk(16'(rv[12:10]), 16'h0005);
      chk(16'(ctrl.inputLimitCut), 16'h0001);
      loops.inVoltLimit <= 1'b0;
      loops.floorReg <= 1'b0;
      cyc(4);
      rd(ADDR_STATUS);
      chk(16'(rv[12:10]), 16'h0000);
      chk(16'(ctrl.inputLimitCut), 16'h0000);
   endtask
   task automatic t_boost;
      loops.boostMode <= 1'b1;
      cyc(4);
      chk(16'(ctrl.boostOn), 16'h0001);
      boostWin <= 2'h2;
      cyc(6);
      chk(16'(ctrl.boostOn), 16'h0000);
      rd(ADDR_STATUS);
      chk(16'(rv[7:2]), 16'h0030);
      boostWin <= 2'h1;
      cyc(6);
      rd(ADDR_STATUS);
      chk(16'(rv[7:2]), 16'h0028);
      boostWin <= 2'h0;
      cyc(6);
      chk(16'(ctrl.boostOn), 16'h0001);
      rd(ADDR_STATUS);
      chk(16'(rv[7:2]), 16'h0007);
      loops.boostMode <= 1'b0;
   endtask
   task automatic t_switch;
      loops.sysBelowBat45 <= 1'b1;
      cyc(4);
      chk(16'({ctrl.switchOn, ctrl.supplement}), 16'h0003);
      loops.batDepleted <= 1'b1;
      cyc(4);
      chk(16'({ctrl.switchOn, ctrl.supplement}), 16'h0000);
      loops.batDepleted <= 1'b0;
      cyc(4);
      // Delay of 12 timer seconds is 48 cycles at four cycles a second
      wr(ADDR_CFG_TIMER, 16'h003F);
      cyc(40);
      chk(16'(ctrl.switchOn), 16'h0001);
      cyc(16);
      chk(16'(ctrl.switchOn), 16'h0000);
      wr(ADDR_CFG_TIMER, 16'h000F);
      cyc(4);
      chk(16'(ctrl.switchOn), 16'h0001);
      wr(ADDR_CFG_TIMER, 16'h001F);
      cyc(3);
      chk(16'(ctrl.switchOn), 16'h0000);
      wr(ADDR_CFG_TIMER, 16'h000F);
      loops.sysBelowBat45 <= 1'b0;
   endtask
   task automatic t_timer;
      int i;
      loops.restart <= 1'b1;
      cyc(1);
      loops.restart <= 1'b0;
      // Two hours of four-cycle seconds is 28800 cycles
      cyc(28700);
      chk(16'(ctrl.chargeOn), 16'h0001);
      for (i = 0; i < 400 && irq_n !== 1'b0; i++)
         step;
      if (irq_n !== 1'b0) begin
         fails++;
         end_sim;
      end
      tF = $realtime;
      rd(ADDR_STATUS);
      chk(16'(rv[9:8]), 16'h0003);
      chk(16'(ctrl.chargeOn), 16'h0000);
      for (i = 0; i < 60000 && irq_n !== 1'b1; i++)
         step;
      if (irq_n !== 1'b1) begin
         fails++;
         end_sim;
      end
      chk(16'(int'(($realtime - tF) / 5.0)), 16'hC800);
      wr(ADDR_CFG_TIMER, 16'h0007);
      wr(ADDR_CFG_TIMER, 16'h000F);
      cyc(4);
      rd(ADDR_STATUS);
      chk(16'(rv[9:8]), 16'h0000);
      chk(16'(ctrl.chargeOn), 16'h0001);
   endtask
   initial begin
      loops = '0;
      loops.batBelowTarget = 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      t_reset;
      t_zones;
      t_flags;
      t_boost;
      t_switch;
      t_timer;
      end_sim;
   end
endmodule
bind chgsup_top chgsup_checker chk_i (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
   .chargeVoltageTarget(chargeVoltageTarget), .chargeEnablePin_n(chargeEnablePin_n),
   .thermistorSense(thermistorSense), .loopStatus(loopStatus), .chargeCtrl(chargeCtrl),
   .hostIrqPulse_n(hostIrqPulse_n));
